// >>> core/uvrb_defines.svh
// constants of the vendor register bank: offsets, fields, reset values, timing
// Summary of operation
// RQ1: immediate and extended addresses reach same registers
// RQ2: vendor range 0x30-0x3F uses immediate accesses
// RQ3: 0x31 bits 6:5 select transmit amplitude
// RQ4: audio mode only when key equals 1010
// RQ5: id register reads 36-38, write/set/clear
// RQ6: line register reads 39-3B, write/set/clear
// RQ7: bits 2:0 carry id resistance code
// RQ8: go bit starts measurement, clears when done
// RQ9: complete flag set after 282 us
// RQ10: vendor read clears complete, carkit read not
// RQ11: irq enable raises alternate interrupt on completion
// RQ12: link keeps id register bit 5 zero
// RQ13: swap bit exchanges the two data pins
// RQ14: bits 3:2 serial regulator level, reset 01
// RQ15: bits 4/5 connect charger pull-ups
// RQ16: bits 7:6 usb regulator level, reset 00
// RQ17: completion with enable sets clear-on-read latch
// RQ18: set/clear addresses act on bits written one
// RQ19: reserved bits read zero, ignore writes
`ifndef UVRB_DEFINES_SVH
`define UVRB_DEFINES_SVH
`define UVRB_IMM_TOP 8'h3F
`define UVRB_VENDOR_BASE 8'h30
`define UVRB_ADDR_TX_AMP 8'h31
`define UVRB_ADDR_AUDIO 8'h33
`define UVRB_ADDR_RID_WR 8'h36
`define UVRB_ADDR_RID_SET 8'h37
`define UVRB_ADDR_RID_CLR 8'h38
`define UVRB_ADDR_LDO_WR 8'h39
`define UVRB_ADDR_LDO_SET 8'h3A
`define UVRB_ADDR_LDO_CLR 8'h3B
`define UVRB_AMP_LSB 5
`define UVRB_AUDIO_KEY 4'hA
`define UVRB_RID_DONE_BIT 3
`define UVRB_RID_GO_BIT 4
`define UVRB_RID_IRQ_BIT 6
`define UVRB_RID_CTRL_MASK 8'h60
`define UVRB_RID_CTRL_RESET 8'h00
`define UVRB_LDO_SWAP_BIT 1
`define UVRB_LDO_SER_LSB 2
`define UVRB_LDO_DP_BIT 4
`define UVRB_LDO_DM_BIT 5
`define UVRB_LDO_USB_LSB 6
`define UVRB_LDO_MASK 8'hFE
`define UVRB_LDO_RESET 8'h04
`define UVRB_CLK_PERIOD_NS 50
`define UVRB_MEASURE_TIME_NS 282000
`define UVRB_MEASURE_CYCLES ((`UVRB_MEASURE_TIME_NS + `UVRB_CLK_PERIOD_NS - 1) / `UVRB_CLK_PERIOD_NS)
`endif

// >>> core/uvrb_pkg.sv
// types shared by the vendor register bank files
package uvrb_pkg;
	// one register access from the link side
	typedef struct packed {
		logic valid; // access offered this cycle
		logic write; // 1 write, 0 read
		logic extended; // address is an extended address
		logic [7:0] addr; // immediate (5:0) or extended address
		logic [7:0] wdata; // write data
	} uvrb_access_s;
	// read answer
	typedef struct packed {
		logic valid; // one-cycle pulse per read
		logic hit; // address belongs to the vendor range
		logic [7:0] data; // read data
	} uvrb_answer_s;
	// measurement sequencer states
	typedef enum logic [0:0] {
		uvrb_meas_idle = 1'b0,
		uvrb_meas_run = 1'b1
	} uvrb_meas_e;
	// state of the bank top
	typedef struct packed {
		logic [1:0] tx_amp;
		logic [3:0] audio_key;
		logic audio_en;
		logic serial_ldo_active;
		logic [1:0] ldo_level;
		logic dp_pullup;
		logic dm_pullup;
		logic swap;
		logic latch;
		logic alt_int;
		uvrb_answer_s answer;
	} uvrb_bank_state_s;
endpackage : uvrb_pkg

// >>> core/uvrb_wsc_reg.sv
// register with plain write, bit-set and bit-clear ports and a mask of live bits
`timescale 1ns/1ps
`default_nettype none
module uvrb_wsc_reg #(
	parameter int WIDTH = 8, // register width
	parameter logic [WIDTH-1:0] RESET = '0, // reset value
	parameter logic [WIDTH-1:0] MASK = '1 // live bits, others read zero
) (
	input wire logic core_clk_in, // clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic wr_in, // plain write strobe
	input wire logic set_in, // bit-set strobe
	input wire logic clr_in, // bit-clear strobe
	input wire logic [WIDTH-1:0] data_in, // write data
	output var logic [WIDTH-1:0] value_out // register contents
);
	typedef struct packed {
		logic [WIDTH-1:0] value;
	} uvrb_wsc_state_s;
	uvrb_wsc_state_s state;
	uvrb_wsc_state_s next_state;
	if (WIDTH < 1) begin : g_chk
		$error("uvrb_wsc_reg: WIDTH must be at least 1");
	end
	// write, set and clear; masked bits stay zero
	always_comb begin
		next_state = state;
		if (wr_in) begin
			next_state.value = data_in & MASK; // RQ19
		end else if (set_in) begin
			next_state.value = (state.value | data_in) & MASK; // RQ18
		end else if (clr_in) begin
			next_state.value = state.value & ~data_in; // RQ18
		end
	end
	// state register
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state.value <= RESET & MASK;
		end else begin
			state <= next_state;
		end
	end
	assign value_out = state.value;
endmodule : uvrb_wsc_reg
`default_nettype wire

// >>> core/uvrb_id_measure.sv
// id resistance measurement sequencer: go bit, timer, result code and complete flag
`timescale 1ns/1ps
`default_nettype none
module uvrb_id_measure #(
	parameter int MEASURE_CYCLES = 5640 // measurement length in clocks
) (
	input wire logic core_clk_in, // clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic start_in, // go written or set to one
	input wire logic abort_in, // go written or cleared to zero
	input wire logic [2:0] sample_code_in, // code from the resistance converter
	input wire logic code_wr_in, // software update of the code field
	input wire logic [2:0] code_data_in, // new code value
	input wire logic done_clr_in, // vendor read of the result
	output logic go_out, // measurement running
	output logic done_out, // complete flag
	output logic done_rise_out, // complete flag went 0 to 1
	output logic [2:0] code_out // result code
);
	localparam int CW = $clog2(MEASURE_CYCLES + 1);
	typedef struct packed {
		uvrb_pkg::uvrb_meas_e mode;
		logic [CW-1:0] count;
		logic go;
		logic done;
		logic rise;
		logic [2:0] code;
	} uvrb_meas_state_s;
	uvrb_meas_state_s state;
	uvrb_meas_state_s next_state;
	if (MEASURE_CYCLES < 1) begin : g_chk
		$error("uvrb_id_measure: MEASURE_CYCLES must be at least 1");
	end
	// sequencer; completion wins over a read clear in the same cycle
	always_comb begin
		next_state = state;
		if (code_wr_in) begin
			next_state.code = code_data_in;
		end
		if (done_clr_in) begin
			next_state.done = 1'b0; // RQ10
		end
		case (state.mode)
			uvrb_pkg::uvrb_meas_idle: begin
				if (start_in) begin
					next_state.mode = uvrb_pkg::uvrb_meas_run; // RQ8
					next_state.go = 1'b1;
					next_state.count = CW'(MEASURE_CYCLES - 1);
				end
			end
			uvrb_pkg::uvrb_meas_run: begin
				if (abort_in) begin
					next_state.mode = uvrb_pkg::uvrb_meas_idle;
					next_state.go = 1'b0;
				end else if (state.count == '0) begin
					next_state.mode = uvrb_pkg::uvrb_meas_idle;
					next_state.go = 1'b0; // RQ8
					next_state.code = sample_code_in; // RQ7
					next_state.done = 1'b1; // RQ9
				end else begin
					next_state.count = state.count - CW'(1);
				end
			end
			default: begin
				next_state.mode = uvrb_pkg::uvrb_meas_idle;
			end
		endcase
		next_state.rise = next_state.done & ~state.done;
	end
	// state register
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign go_out = state.go;
	assign done_out = state.done;
	assign done_rise_out = state.rise;
	assign code_out = state.code;
endmodule : uvrb_id_measure
`default_nettype wire

// >>> core/uvrb_register_bank.sv
// vendor register bank: address decode, vendor registers, regulator and pin controls
`timescale 1ns/1ps
`default_nettype none
`include "uvrb_defines.svh"
module uvrb_register_bank #(
	parameter int MEASURE_CYCLES = `UVRB_MEASURE_CYCLES // measurement length in clocks
) (
	input wire logic core_clk_in, // 20 MHz clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire uvrb_pkg::uvrb_access_s access_in, // register access from link
	output var uvrb_pkg::uvrb_answer_s answer_out, // read answer, one cycle later
	input wire logic serial_mode_in, // phy is in serial (uart) mode
	input wire logic serial_tx_enable_in, // serial transmit enable
	input wire logic [2:0] id_resistance_sample_in, // converter code
	input wire logic carkit_irq_en_in, // enable copy in the carkit register
	input wire logic carkit_latch_read_in, // read of the carkit latch register
	output logic [1:0] hs_tx_amplitude_out, // transmit amplitude select
	output logic audio_passthrough_en_out, // headset audio mode
	output logic line_pair_swap_out, // exchange data pins
	output logic dp_charger_pullup_out, // d+ charger pull-up
	output logic dm_charger_pullup_out, // d- charger pull-up
	output logic [1:0] ldo_level_out, // regulator level in use
	output logic [2:0] id_resistance_code_out, // code for carkit status copy
	output logic id_measure_complete_out, // complete flag for carkit copy
	output logic id_measure_go_out, // measurement running
	output logic id_measure_latch_out, // latched measurement interrupt
	output logic alt_int_out // alternate interrupt pulse for rxcmd
);
	if (MEASURE_CYCLES < 1) begin : g_chk
		$error("uvrb_register_bank: MEASURE_CYCLES must be at least 1");
	end

	// every two-bit field must sit inside an eight-bit register
	if ((`UVRB_AMP_LSB > 6) || (`UVRB_LDO_SER_LSB > 6) || (`UVRB_LDO_USB_LSB > 6)) begin : g_field_chk
		$error("uvrb_register_bank: field outside the register");
	end

	// the clear offset must sit two above each write offset
	if ((`UVRB_ADDR_RID_CLR != `UVRB_ADDR_RID_WR + 8'h02)
		|| (`UVRB_ADDR_LDO_CLR != `UVRB_ADDR_LDO_WR + 8'h02)) begin : g_addr_chk
		$error("uvrb_register_bank: set and clear offsets misplaced");
	end

	uvrb_pkg::uvrb_bank_state_s state;
	uvrb_pkg::uvrb_bank_state_s next_state;

	// address decode
	logic addr_ok;
	logic [7:0] eff_addr;
	logic vendor_hit;
	logic vend_wr;
	logic vend_rd;
	logic [7:0] wdata;

	// an extended address reaches the same registers as the immediate one
	assign addr_ok = access_in.extended ? (access_in.addr <= `UVRB_IMM_TOP) : 1'b1; // RQ1
	assign eff_addr = {2'b00, access_in.addr[5:0]}; // RQ1
	assign vendor_hit = access_in.valid & addr_ok & (eff_addr >= `UVRB_VENDOR_BASE); // RQ2
	assign vend_wr = vendor_hit & access_in.write;
	assign vend_rd = vendor_hit & ~access_in.write;
	assign wdata = access_in.wdata;

	// strobes of the id measurement register group
	logic rid_wr;
	logic rid_set;
	logic rid_clr;
	logic rid_rd;

	// strobes of the line and regulator register group
	logic ldo_wr;
	logic ldo_set;
	logic ldo_clr;

	// write, set and clear each have their own address
	assign rid_wr = vend_wr & (eff_addr == `UVRB_ADDR_RID_WR); // RQ5
	assign rid_set = vend_wr & (eff_addr == `UVRB_ADDR_RID_SET); // RQ5
	assign rid_clr = vend_wr & (eff_addr == `UVRB_ADDR_RID_CLR); // RQ5
	assign ldo_wr = vend_wr & (eff_addr == `UVRB_ADDR_LDO_WR); // RQ6
	assign ldo_set = vend_wr & (eff_addr == `UVRB_ADDR_LDO_SET); // RQ6
	assign ldo_clr = vend_wr & (eff_addr == `UVRB_ADDR_LDO_CLR); // RQ6

	// a read at any of the three id addresses returns the result
	assign rid_rd = vend_rd & (eff_addr >= `UVRB_ADDR_RID_WR) & (eff_addr <= `UVRB_ADDR_RID_CLR); // RQ5

	// registers that answer at one offset only, and the line register read
	logic amp_wr;
	logic audio_wr;
	logic amp_rd;
	logic audio_rd;
	logic ldo_rd;

	// plain read/write registers: one address each
	assign amp_wr = vend_wr & (eff_addr == `UVRB_ADDR_TX_AMP); // RQ3
	assign audio_wr = vend_wr & (eff_addr == `UVRB_ADDR_AUDIO); // RQ4
	assign amp_rd = vend_rd & (eff_addr == `UVRB_ADDR_TX_AMP); // RQ3
	assign audio_rd = vend_rd & (eff_addr == `UVRB_ADDR_AUDIO); // RQ4
	// the line register reads back at all three of its addresses
	assign ldo_rd = vend_rd & (eff_addr >= `UVRB_ADDR_LDO_WR) & (eff_addr <= `UVRB_ADDR_LDO_CLR); // RQ6

	// interrupt enable and reserved bit 6:5 of the id register
	logic [7:0] rid_ctrl;

	uvrb_wsc_reg #(
		.WIDTH(8),
		.RESET(`UVRB_RID_CTRL_RESET),
		.MASK(`UVRB_RID_CTRL_MASK)
	) u_rid_ctrl (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(rid_wr),
		.set_in(rid_set),
		.clr_in(rid_clr),
		.data_in(wdata),
		.value_out(rid_ctrl)
	);

	// line swap, pull-ups and regulator levels; bit 0 stays zero
	logic [7:0] ldo_reg;

	uvrb_wsc_reg #(
		.WIDTH(8),
		.RESET(`UVRB_LDO_RESET),
		.MASK(`UVRB_LDO_MASK)
	) u_ldo_reg (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(ldo_wr),
		.set_in(ldo_set),
		.clr_in(ldo_clr),
		.data_in(wdata),
		.value_out(ldo_reg)
	);

	// levels that each mode selects and what calls for the serial one
	logic serial_req;
	logic [1:0] serial_level;
	logic [1:0] usb_level;
	logic dp_req;
	logic dm_req;

	// serial level is wanted once serial mode runs with transmit enabled
	assign serial_req = serial_mode_in & serial_tx_enable_in; // RQ14
	assign serial_level = ldo_reg[`UVRB_LDO_SER_LSB +: 2]; // RQ14
	assign usb_level = ldo_reg[`UVRB_LDO_USB_LSB +: 2]; // RQ16

	// charger pull-ups: register bit, or forced on in serial mode
	assign dp_req = ldo_reg[`UVRB_LDO_DP_BIT] | serial_mode_in; // RQ15
	assign dm_req = ldo_reg[`UVRB_LDO_DM_BIT] | serial_mode_in; // RQ15

	// measurement start, abort and code update
	logic meas_start;
	logic meas_abort;
	logic code_wr;
	logic [2:0] code_data;
	logic meas_go;
	logic meas_done;
	logic meas_rise;
	logic [2:0] meas_code;

	// go asserted by a write or set operation starts a measurement
	assign meas_start = (rid_wr | rid_set) & wdata[`UVRB_RID_GO_BIT]; // RQ8
	// go written to zero or cleared stops a measurement early
	assign meas_abort = (rid_wr & ~wdata[`UVRB_RID_GO_BIT]) | (rid_clr & wdata[`UVRB_RID_GO_BIT]);
	// code field follows write, set and clear like the other bits
	assign code_wr = rid_wr | rid_set | rid_clr; // RQ18
	always_comb begin
		if (rid_wr) begin
			code_data = wdata[2:0];
		end else if (rid_set) begin
			code_data = meas_code | wdata[2:0]; // RQ18
		end else begin
			code_data = meas_code & ~wdata[2:0]; // RQ18
		end
	end

	uvrb_id_measure #(
		.MEASURE_CYCLES(MEASURE_CYCLES)
	) u_id_measure (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		// control from the link side
		.start_in(meas_start),
		.abort_in(meas_abort),
		// converter sample and software code update
		.sample_code_in(id_resistance_sample_in),
		.code_wr_in(code_wr),
		.code_data_in(code_data),
		.done_clr_in(rid_rd), // RQ10
		// measurement results
		.go_out(meas_go),
		.done_out(meas_done),
		.done_rise_out(meas_rise),
		.code_out(meas_code)
	);

	// enable is the or of the vendor bit and its carkit copy
	logic irq_en;
	logic irq_event;

	assign irq_en = rid_ctrl[`UVRB_RID_IRQ_BIT] | carkit_irq_en_in; // RQ11
	assign irq_event = meas_rise & irq_en; // RQ11

	// read views of the registers, reserved bits forced to zero
	logic [7:0] amp_view;
	logic [7:0] audio_view;
	logic [7:0] rid_view;
	logic [7:0] rd_data;
	logic rd_req;

	assign amp_view = {1'b0, state.tx_amp, 5'h00}; // RQ19
	assign audio_view = {4'h0, state.audio_key}; // RQ19

	// a read offered this cycle, answered at the next edge
	assign rd_req = access_in.valid & ~access_in.write;

	// live go, complete flag and code over the stored control bits
	always_comb begin
		rid_view = rid_ctrl;
		rid_view[`UVRB_RID_GO_BIT] = meas_go;
		rid_view[`UVRB_RID_DONE_BIT] = meas_done; // RQ9
		rid_view[2:0] = meas_code; // RQ7
	end

	// unused vendor addresses read zero
	always_comb begin
		rd_data = 8'h00;
		if (amp_rd) begin
			rd_data = amp_view; // RQ3
		end else if (audio_rd) begin
			rd_data = audio_view; // RQ4
		end else if (rid_rd) begin
			rd_data = rid_view; // RQ5
		end else if (ldo_rd) begin
			rd_data = ldo_reg; // RQ6
		end
	end

	// next state of the bank
	always_comb begin
		next_state = state;

		// plain read/write registers
		if (amp_wr) begin
			next_state.tx_amp = wdata[`UVRB_AMP_LSB +: 2]; // RQ3
		end
		if (audio_wr) begin
			next_state.audio_key = wdata[3:0];
		end

		// audio mode needs the exact key
		next_state.audio_en = (next_state.audio_key == `UVRB_AUDIO_KEY); // RQ4

		// serial level holds once serial mode is entered with transmit enabled
		if (!serial_mode_in) begin
			next_state.serial_ldo_active = 1'b0;
		end else if (serial_req) begin
			next_state.serial_ldo_active = 1'b1; // RQ14
		end

		// regulator level in use
		if (next_state.serial_ldo_active) begin
			next_state.ldo_level = serial_level; // RQ14
		end else begin
			next_state.ldo_level = usb_level; // RQ16
		end

		// pull-ups, forced on in serial mode
		next_state.dp_pullup = dp_req; // RQ15
		next_state.dm_pullup = dm_req; // RQ15

		// data pin exchange, also for serial routing
		next_state.swap = ldo_reg[`UVRB_LDO_SWAP_BIT]; // RQ13

		// latched interrupt: a new event wins over the clearing read
		if (irq_event) begin
			next_state.latch = 1'b1; // RQ17
		end else if (carkit_latch_read_in) begin
			next_state.latch = 1'b0; // RQ17
		end

		// alternate interrupt pulse toward the rxcmd byte
		next_state.alt_int = irq_event; // RQ11

		// read answer, one cycle after the request
		next_state.answer.valid = rd_req;
		next_state.answer.hit = vend_rd;
		next_state.answer.data = vend_rd ? rd_data : 8'h00;
	end

	// state register
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flip-flops: read answer
	assign answer_out = state.answer;

	// transmitter and audio controls
	assign hs_tx_amplitude_out = state.tx_amp;
	assign audio_passthrough_en_out = state.audio_en;

	// data pin routing and charger pull-ups
	assign line_pair_swap_out = state.swap;
	assign dp_charger_pullup_out = state.dp_pullup;
	assign dm_charger_pullup_out = state.dm_pullup;

	// regulator level in use
	assign ldo_level_out = state.ldo_level;

	// measurement result copies for the carkit status register
	assign id_resistance_code_out = meas_code;
	assign id_measure_complete_out = meas_done;
	assign id_measure_go_out = meas_go;

	// interrupt latch and rxcmd pulse
	assign id_measure_latch_out = state.latch;
	assign alt_int_out = state.alt_int;
endmodule : uvrb_register_bank
`default_nettype wire

// >>> tb/uvrb_bank_chk.sv
// port checker of the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module uvrb_bank_chk #(
	parameter int MEASURE_CYCLES = 8 // measurement length in clocks
) (
	input wire logic core_clk_in, // clock
	input wire logic rst_n_in, // reset, active low
	input wire uvrb_pkg::uvrb_access_s access_in, // access from link
	input wire uvrb_pkg::uvrb_answer_s answer_out, // read answer
	input wire logic serial_mode_in, // serial mode
	input wire logic carkit_irq_en_in, // carkit enable copy
	input wire logic carkit_latch_read_in, // carkit latch read
	input wire logic audio_passthrough_en_out, // audio mode
	input wire logic dp_charger_pullup_out, // d+ pull-up
	input wire logic dm_charger_pullup_out, // d- pull-up
	input wire logic id_measure_complete_out, // complete flag
	input wire logic id_measure_go_out, // go bit
	input wire logic id_measure_latch_out, // latch
	input wire logic alt_int_out // alternate interrupt
);
	logic ok;
	logic rd;
	logic wr;
	logic vend;
	logic irq_sh;
	logic [15:0] run_cnt;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// decode of the offered access
	assign ok = access_in.valid && (!access_in.extended || access_in.addr <= 8'h3F);
	assign rd = access_in.valid && !access_in.write;
	assign wr = ok && access_in.write;
	assign vend = ok && access_in.addr[5:4] == 2'b11;
	// length of the running go bit and a copy of the vendor irq enable
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			run_cnt <= 16'h0000;
			irq_sh <= 1'b0;
		end else begin
			run_cnt <= id_measure_go_out ? run_cnt + 16'h0001 : 16'h0000;
			irq_sh <= (wr && access_in.addr[5:0] == 6'h36) ? access_in.wdata[6] :
				(wr && access_in.addr[5:0] == 6'h37 && access_in.wdata[6]) ? 1'b1 :
				(wr && access_in.addr[5:0] == 6'h38 && access_in.wdata[6]) ? 1'b0 : irq_sh;
		end
	end
	read_answer_a: assert property (rd |=> answer_out.valid) else $error("read gave no answer");
	no_answer_a: assert property (!rd |=> !answer_out.valid) else $error("answer without read");
	vendor_hit_a: assert property (rd && vend |=> answer_out.hit) else $error("vendor read missed");
	outside_miss_a: assert property (rd && !vend |=> !answer_out.hit && answer_out.data == 8'h00)
		else $error("outside read hit");
	answer_idle_a: assert property (!answer_out.valid |-> !answer_out.hit && answer_out.data == 8'h00)
		else $error("idle answer not zero");
	audio_key_a: assert property (wr && access_in.addr[5:0] == 6'h33 |-> ##2
		audio_passthrough_en_out == ($past(access_in.wdata[3:0], 2) == 4'hA)) else $error("audio key wrong");
	measure_len_a: assert property ($rose(id_measure_complete_out) |->
		$fell(id_measure_go_out) && run_cnt == 16'(MEASURE_CYCLES)) else $error("measure length wrong");
	irq_raise_a: assert property ($rose(id_measure_complete_out) && (irq_sh || carkit_irq_en_in) |=>
		alt_int_out && id_measure_latch_out) else $error("no interrupt on completion");
	irq_quiet_a: assert property (!$rose(id_measure_complete_out) |=> !alt_int_out) else $error("stray interrupt");
	latch_clear_a: assert property (carkit_latch_read_in |=> !id_measure_latch_out || alt_int_out)
		else $error("latch not cleared");
	serial_pull_a: assert property (serial_mode_in && $past(serial_mode_in) && $past(rst_n_in) |->
		dp_charger_pullup_out && dm_charger_pullup_out) else $error("pull-ups off in serial mode");
endmodule : uvrb_bank_chk
bind uvrb_register_bank uvrb_bank_chk #(.MEASURE_CYCLES(MEASURE_CYCLES)) u_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .access_in(access_in), .answer_out(answer_out),
	.serial_mode_in(serial_mode_in), .carkit_irq_en_in(carkit_irq_en_in),
	.carkit_latch_read_in(carkit_latch_read_in), .audio_passthrough_en_out(audio_passthrough_en_out),
	.dp_charger_pullup_out(dp_charger_pullup_out), .dm_charger_pullup_out(dm_charger_pullup_out),
	.id_measure_complete_out(id_measure_complete_out), .id_measure_go_out(id_measure_go_out),
	.id_measure_latch_out(id_measure_latch_out), .alt_int_out(alt_int_out)
);
`default_nettype wire

// >>> tb/uvrb_link_model.sv
// link controller model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module uvrb_link_model (
	input wire logic core_clk_in, // clock
	output var uvrb_pkg::uvrb_access_s access_out, // access toward the bank
	input wire uvrb_pkg::uvrb_answer_s answer_in // read answer
);
	// released bus shows no stale address or data
	task automatic idle();
		access_out.valid = 1'b0;
		access_out.addr = ~access_out.addr;
		access_out.wdata = ~access_out.wdata;
	endtask : idle
	// one access held over one rising edge, answer taken in the cycle after
	task automatic xfer(input logic w, input logic ext, input logic [7:0] a, input logic [7:0] d,
		output uvrb_pkg::uvrb_answer_s ans);
		@(negedge core_clk_in);
		access_out.valid = 1'b1;
		access_out.write = w;
		access_out.extended = ext;
		access_out.addr = a;
		access_out.wdata = (w && (a[5:0] == 6'h36 || a[5:0] == 6'h37)) ? d & 8'hDF : d;
		@(negedge core_clk_in);
		ans = answer_in;
		idle();
	endtask : xfer
	// quiet bus at time zero
	initial begin
		access_out = '0;
	end
endmodule : uvrb_link_model
`default_nettype wire

// >>> tb/uvrb_register_bank_tb_top.sv
// testbench of the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module uvrb_register_bank_tb_top;
	typedef struct packed {
		logic ext;
		logic [7:0] wa;
		logic [7:0] wd;
		logic [7:0] ra;
		logic [7:0] exp;
	} uvrb_row_s;
	localparam int MC = 8; // shortened measurement
	logic core_clk_in;
	logic rst_n_in;
	uvrb_pkg::uvrb_access_s acc;
	uvrb_pkg::uvrb_answer_s answer;
	uvrb_pkg::uvrb_answer_s ans;
	logic ser;
	logic ser_tx;
	logic [2:0] sample;
	logic ck_en;
	logic latch_rd;
	logic [1:0] amp;
	logic audio;
	logic swap;
	logic dp;
	logic dm;
	logic [1:0] ldo;
	logic [2:0] code;
	logic done;
	logic go;
	logic latch;
	logic alt;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int i;
	logic [7:0] ra4 [4] = '{8'h31, 8'h33, 8'h36, 8'h39};
	// write, read-back and expected value, one row a case
	uvrb_row_s rows [12] = '{
		'{1'b0, 8'h31, 8'hFF, 8'h31, 8'h60}, '{1'b1, 8'h31, 8'h40, 8'h31, 8'h40},
		'{1'b0, 8'h33, 8'hFF, 8'h33, 8'h0F}, '{1'b0, 8'hB3, 8'h0A, 8'h33, 8'h0A},
		'{1'b0, 8'h39, 8'hFF, 8'h3B, 8'hFE}, '{1'b0, 8'h3B, 8'h0C, 8'h39, 8'hF2},
		'{1'b0, 8'h3A, 8'h04, 8'h3A, 8'hF6}, '{1'b0, 8'h36, 8'h44, 8'h38, 8'h44},
		'{1'b0, 8'h38, 8'h40, 8'h37, 8'h04}, '{1'b0, 8'h37, 8'h02, 8'h36, 8'h06},
		'{1'b1, 8'h7F, 8'hFF, 8'h30, 8'h00}, '{1'b0, 8'h20, 8'hFF, 8'h20, 8'h00}};
	uvrb_link_model link (.core_clk_in(core_clk_in), .access_out(acc), .answer_in(answer));
	uvrb_register_bank #(.MEASURE_CYCLES(MC)) dut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .access_in(acc), .answer_out(answer),
		.serial_mode_in(ser), .serial_tx_enable_in(ser_tx), .id_resistance_sample_in(sample),
		.carkit_irq_en_in(ck_en), .carkit_latch_read_in(latch_rd), .hs_tx_amplitude_out(amp),
		.audio_passthrough_en_out(audio), .line_pair_swap_out(swap), .dp_charger_pullup_out(dp),
		.dm_charger_pullup_out(dm), .ldo_level_out(ldo), .id_resistance_code_out(code),
		.id_measure_complete_out(done), .id_measure_go_out(go), .id_measure_latch_out(latch), .alt_int_out(alt)
	);
	// compare one value and count it
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// counts, verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	// free-running clock
	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end
	// hang guard
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		{rst_n_in, ser, ser_tx, sample, ck_en, latch_rd} = '0;
		repeat (5) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		for (i = 0; i < 4; i++) begin
			link.xfer(1'b0, 1'b0, ra4[i], 8'h00, ans);
			chk("reset value", ans.data, (i == 3) ? 8'h04 : 8'h00);
		end
		chk("reset ldo", 8'(ldo), 8'h00);
		$display("reset test done");
		for (i = 0; i < 12; i++) begin
			link.xfer(1'b1, rows[i].ext, rows[i].wa, rows[i].wd, ans);
			link.xfer(1'b0, rows[i].ext, rows[i].ra, 8'h00, ans);
			chk("readback", ans.data, rows[i].exp);
			chk("hit", 8'(ans.hit), 8'(rows[i].ra[5:4] == 2'b11 && (!rows[i].ext || rows[i].ra <= 8'h3F)));
		end
		chk("amplitude", 8'(amp), 8'h02);
		chk("audio", 8'(audio), 8'h01);
		$display("row test done");
		for (i = 0; i < 2; i++) begin
			ck_en = i[0];
			sample = i[0] ? 3'h7 : 3'h5;
			link.xfer(1'b1, 1'b0, i[0] ? 8'h36 : 8'h37, i[0] ? 8'h10 : 8'h50, ans);
			chk("go", 8'(go), 8'h01);
			for (int k = 0; k < 30 && done !== 1'b1; k++) @(negedge core_clk_in);
			chk("result", 8'({go, done, code}), {3'h0, 1'b0, 1'b1, sample});
			@(negedge core_clk_in);
			chk("irq", 8'({alt, latch}), 8'h03);
			link.xfer(1'b0, 1'b0, 8'h36, 8'h00, ans);
			chk("measure read", ans.data, i[0] ? 8'h0F : 8'h4D);
			chk("complete cleared", 8'(done), 8'h00);
			latch_rd = 1'b1;
			@(negedge core_clk_in);
			latch_rd = 1'b0;
			chk("latch cleared", 8'(latch), 8'h00);
		end
		link.xfer(1'b1, 1'b0, 8'h37, 8'h10, ans);
		link.xfer(1'b1, 1'b0, 8'h38, 8'h10, ans);
		link.xfer(1'b0, 1'b0, 8'h36, 8'h00, ans);
		chk("abort go", 8'(go), 8'h00);
		chk("abort", ans.data, 8'h07);
		$display("measure test done");
		link.xfer(1'b1, 1'b0, 8'h39, 8'h4A, ans);
		ser = 1'b1;
		ser_tx = 1'b1;
		repeat (3) @(negedge core_clk_in);
		chk("serial ldo", 8'({dp, dm, ldo}), 8'h0E);
		chk("swap", 8'(swap), 8'h01);
		ser = 1'b0;
		repeat (3) @(negedge core_clk_in);
		chk("usb ldo", 8'({dp, dm, ldo}), 8'h01);
		$display("serial test done");
		rst_n_in = 1'b0;
		@(negedge core_clk_in);
		rst_n_in = 1'b1;
		chk("reset outputs", 8'({ldo, swap, audio, dp, dm}), 8'h00);
		link.xfer(1'b0, 1'b0, 8'h39, 8'h00, ans);
		chk("ldo after reset", ans.data, 8'h04);
		$display("mid-run reset test done");
		stop_test();
	end
endmodule : uvrb_register_bank_tb_top
`default_nettype wire
